// File: pcitr_pkg.sv
package pcitr_pkg;
    // bus widths
    localparam int DW = 32;
    localparam int LW = 64;
    localparam int TSV_W = 12;
    // read commands seen on the command lines in the address phase
    localparam logic [3:0] CMD_IO_RD = 4'h2;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_CFG_RD = 4'ha;
    localparam logic [3:0] CMD_MEM_RDM = 4'hc;
    localparam logic [3:0] CMD_MEM_RDL = 4'he;
    // byte enables the master drives in a read data phase (all lanes)
    localparam logic [3:0] BE_ALL = 4'h0;
    // target status vector bit positions
    localparam int TSV_RANGE0 = 0;
    localparam int TSV_RANGE1 = 1;
    localparam int TSV_WIDE = 7;
    localparam int TSV_BURST = 9;
    localparam int TSV_DONE = 10;
    // address bit that picks the high dword of a qword
    localparam int QW_SEL_BIT = 2;
    // config space dword indices served internally
    localparam logic [5:0] CFG_ID_IDX = 6'h00;
    localparam logic [5:0] CFG_BAR0_IDX = 6'h04;
    localparam logic [5:0] CFG_BASE_RANGE_ONE_IDX = 6'h05;
    // io space indicator bit of a base range word
    localparam logic [31:0] CFG_IO_FLAG = 32'h0000_0001;
    // cycles the master waits for a claim before giving up
    localparam int ABORT_CYCLES = 5;
    // target and master state machines, one-hot
    typedef enum logic [3:0] {
        T_IDLE = 4'h1,
        T_DECODE = 4'h2,
        T_DATA = 4'h4,
        T_DONE = 4'h8
    } pcitr_tstate_t;
    typedef enum logic [3:0] {
        M_IDLE = 4'h1,
        M_ADDR = 4'h2,
        M_DATA = 4'h4,
        M_END = 4'h8
    } pcitr_mstate_t;
endpackage : pcitr_pkg

// File: pcitr_if.sv
`timescale 1ns/100ps
interface pcitr_if;
    // master-driven lines and their enables
    logic [31:0] m_ad;
    logic m_ad_oe;
    logic m_oe; // enables framen, irdyn, req64n, cben, idsel
    logic [3:0] cben_o;
    logic framen_o;
    logic irdyn_o;
    logic req64n_o;
    logic idsel_o;
    // target-driven lines and their enables
    logic [31:0] t_ad;
    logic t_ad_oe;
    logic t_oe; // enables trdyn, devseln, stopn, ack64n
    logic trdyn_o;
    logic devseln_o;
    logic stopn_o;
    logic ack64n_o;
    logic par_o;
    logic par_oe;
    // resolved wire levels; released lines float high through pull-ups, except idsel, which rests low
    logic [31:0] ad;
    logic [3:0] cben;
    logic framen;
    logic irdyn;
    logic req64n;
    logic idsel;
    logic trdyn;
    logic devseln;
    logic stopn;
    logic ack64n;
    logic par;
    // target wins the ad lines only when it drives; turnaround keeps them apart
    assign ad = t_ad_oe ? t_ad : (m_ad_oe ? m_ad : '1);
    assign cben = m_oe ? cben_o : '1;
    assign framen = m_oe ? framen_o : 1'b1;
    assign irdyn = m_oe ? irdyn_o : 1'b1;
    assign req64n = m_oe ? req64n_o : 1'b1;
    assign idsel = m_oe ? idsel_o : 1'b0;
    assign trdyn = t_oe ? trdyn_o : 1'b1;
    assign devseln = t_oe ? devseln_o : 1'b1;
    assign stopn = t_oe ? stopn_o : 1'b1;
    assign ack64n = t_oe ? ack64n_o : 1'b1;
    assign par = par_oe ? par_o : 1'b1;
    modport target (
        input ad, cben, framen, irdyn, req64n, idsel,
        output t_ad, t_ad_oe, t_oe, trdyn_o, devseln_o, stopn_o, ack64n_o, par_o, par_oe
    );
    modport master (
        input ad, trdyn, devseln, stopn, ack64n, par,
        output m_ad, m_ad_oe, m_oe, cben_o, framen_o, irdyn_o, req64n_o, idsel_o
    );
endinterface : pcitr_if

// File: pcitr_master.sv
`timescale 1ns/100ps
module pcitr_master
#(
    parameter int CNT_W = 8
)
(
    input wire logic clk,
    input wire logic arst_n,
    pcitr_if.master bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [3:0] cmd_code,
    input wire logic [31:0] cmd_addr,
    input wire logic [CNT_W-1:0] cmd_count,
    input wire logic cmd_cfg,
    output logic rd_valid,
    output logic [31:0] rd_data,
    output logic done,
    output logic aborted
);
    if (CNT_W < 1 || CNT_W > 16)
    begin : g_bad_cnt
        $error("pcitr_master: CNT_W out of range");
    end

    // whole state of the master in one record
    typedef struct packed {
        pcitr_pkg::pcitr_mstate_t st;
        logic [CNT_W-1:0] left; // dwords still wanted
        logic [2:0] wcnt; // cycles waited for a claim
        logic [31:0] ad;
        logic ad_oe;
        logic m_oe;
        logic [3:0] cben;
        logic framen;
        logic irdyn;
        logic idsel;
        logic cmd_ready;
        logic rd_valid;
        logic [31:0] rd_data;
        logic done;
        logic aborted;
    } pcitr_mreg_t;

    localparam pcitr_mreg_t M_RST = '{st: pcitr_pkg::M_IDLE, framen: 1'b1, irdyn: 1'b1,
        cben: 4'hf, default: '0};
    localparam logic [CNT_W-1:0] ONE = CNT_W'(1);
    localparam logic [2:0] ABORT_AT = 3'(pcitr_pkg::ABORT_CYCLES);

    pcitr_mreg_t r; // registered state
    pcitr_mreg_t next_r; // next state

    // next-state logic
    always_comb
    begin
        logic phase_end;
        logic xfer;
        logic [CNT_W-1:0] left_after;
        phase_end = (r.st == pcitr_pkg::M_DATA) && !r.irdyn && (!bus.trdyn || !bus.stopn);
        xfer = phase_end && !bus.trdyn;
        left_after = xfer ? r.left - ONE : r.left;
        next_r = r;
        next_r.rd_valid = xfer; // one pulse per dword taken
        next_r.done = 1'b0;
        if (xfer)
        begin
            next_r.rd_data = bus.ad;
        end
        case (r.st)
            pcitr_pkg::M_IDLE:
            begin
                next_r.cmd_ready = 1'b1;
                if (cmd_valid && r.cmd_ready)
                begin
                    // address phase; only 32-bit reads are issued
                    next_r.st = pcitr_pkg::M_ADDR;
                    next_r.cmd_ready = 1'b0;
                    next_r.left = (cmd_count == '0) ? ONE : cmd_count;
                    next_r.ad = cmd_addr;
                    next_r.ad_oe = 1'b1;
                    next_r.m_oe = 1'b1;
                    next_r.cben = cmd_code;
                    next_r.framen = 1'b0;
                    next_r.idsel = cmd_cfg;
                    next_r.aborted = 1'b0;
                    next_r.wcnt = '0;
                end
            end
            pcitr_pkg::M_ADDR:
            begin
                // release ad for the target, ask for data on all lanes
                next_r.st = pcitr_pkg::M_DATA;
                next_r.ad_oe = 1'b0;
                next_r.cben = pcitr_pkg::BE_ALL;
                next_r.idsel = 1'b0;
                next_r.irdyn = 1'b0;
                next_r.framen = (r.left == ONE);
            end
            pcitr_pkg::M_DATA:
            begin
                if (bus.devseln && r.wcnt != ABORT_AT)
                begin
                    next_r.wcnt = r.wcnt + 3'h1;
                end
                if (phase_end && r.framen)
                begin
                    // last phase done: drive lines high one cycle
                    next_r.st = pcitr_pkg::M_END;
                    next_r.irdyn = 1'b1;
                    next_r.framen = 1'b1;
                end
                else if (bus.devseln && r.wcnt == ABORT_AT)
                begin
                    // nobody claimed the cycle
                    next_r.st = pcitr_pkg::M_END;
                    next_r.irdyn = 1'b1;
                    next_r.framen = 1'b1;
                    next_r.aborted = 1'b1;
                end
                else if (!bus.stopn || left_after == ONE)
                begin
                    // stop seen or one dword left: next phase is the last
                    next_r.framen = 1'b1;
                end
                next_r.left = left_after;
            end
            pcitr_pkg::M_END:
            begin
                next_r.st = pcitr_pkg::M_IDLE;
                next_r.m_oe = 1'b0;
                next_r.cben = 4'hf;
                next_r.done = 1'b1;
            end
            default:
            begin
                next_r = M_RST;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            r <= M_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign bus.m_ad = r.ad;
    assign bus.m_ad_oe = r.ad_oe;
    assign bus.m_oe = r.m_oe;
    assign bus.cben_o = r.cben;
    assign bus.framen_o = r.framen;
    assign bus.irdyn_o = r.irdyn;
    assign bus.req64n_o = 1'b1;
    assign bus.idsel_o = r.idsel;
    assign cmd_ready = r.cmd_ready;
    assign rd_valid = r.rd_valid;
    assign rd_data = r.rd_data;
    assign done = r.done;
    assign aborted = r.aborted;
endmodule : pcitr_master

// File: pcitr_target.sv
`timescale 1ns/100ps
// How it works
// - ready dropped: strobe withheld, then wait state
// - 64-bit local data feeds 32-bit bus
// - fetch whole qword, send one dword per phase
// - qword-aligned start: low first, both acks
// - odd-dword start: high first, low ack off
// - 32-bit read: no req64n, no ack64n
// - wide status bit low marks 32-bit read
// - dword on ad after transfer, parity next
// - local waits inserted between qword transfers
// - non-prefetching local side disconnects after one
// - io reads single dword, command shows kind
// - status names hit range; acks idle on io
// - local side checks io address byte enables
// - config reads answered without local side
// - config read only with idsel asserted
// - config trdyn not gated by local ready
// - local disconnect ignored on config reads
// - burst bit set on framen and irdyn
module pcitr_target
#(
    parameter logic [31:0] MEM_BASE = 32'h1000_0000,
    parameter logic [31:0] MEM_MASK = 32'hffff_0000,
    parameter logic [31:0] IO_BASE = 32'h0000_1000,
    parameter logic [31:0] IO_MASK = 32'hffff_ff00,
    parameter logic [31:0] CFG_ID = 32'h5a5a_0001 // arbitrary identity word
)
(
    input wire logic clk,
    input wire logic arst_n,
    pcitr_if.target bus,
    input wire logic local_ready_n,
    input wire logic local_disc_n,
    input wire logic [63:0] local_data,
    output logic local_xfer_strobe_n,
    output logic local_ldat_ack_n,
    output logic local_hdat_ack_n,
    output logic local_frame_n,
    output logic [3:0] local_command_out,
    output logic [31:0] local_addr_out,
    output logic [11:0] target_status_vector
);
    if ((MEM_BASE & ~MEM_MASK) != '0 || (IO_BASE & ~IO_MASK) != '0)
    begin : g_bad_base
        $error("pcitr_target: base has bits outside its mask");
    end

    // whole state of the target in one record
    typedef struct packed {
        pcitr_pkg::pcitr_tstate_t st;
        logic fr_q; // framen one cycle ago, finds the address phase
        logic [3:0] cmd;
        logic [31:0] addr;
        logic cfg; // config read claimed
        logic io; // io read claimed
        logic wide; // master asked for 64 bits
        logic [1:0] hit; // {range one, range zero}
        logic issued; // a local strobe has been issued
        logic pushed; // first word is in the buffer
        logic disc; // local side asked to disconnect
        logic [1:0][63:0] fifo; // two-entry qword buffer, entry 0 is head
        logic [1:0] occ; // entries held
        logic hhalf; // next dword out is the high half of the head
        logic [31:0] ad;
        logic ad_oe;
        logic par;
        logic par_oe;
        logic t_oe;
        logic trdyn;
        logic devseln;
        logic stopn;
        logic xfer_n;
        logic ldat_n;
        logic hdat_n;
        logic lframe_n;
        logic [11:0] tsv;
    } pcitr_treg_t;

    // everything released and inactive out of reset
    localparam pcitr_treg_t T_RST = '{st: pcitr_pkg::T_IDLE, fr_q: 1'b1, trdyn: 1'b1,
        devseln: 1'b1, stopn: 1'b1, xfer_n: 1'b1, ldat_n: 1'b1, hdat_n: 1'b1,
        lframe_n: 1'b1, default: '0};

    pcitr_treg_t r; // registered state
    pcitr_treg_t next_r; // next state

    // config space words; nothing here needs the local side
    function automatic logic [31:0] pcitr_cfg_word(input logic [5:0] idx);
        case (idx)
            pcitr_pkg::CFG_ID_IDX: pcitr_cfg_word = CFG_ID;
            pcitr_pkg::CFG_BAR0_IDX: pcitr_cfg_word = MEM_BASE;
            pcitr_pkg::CFG_BASE_RANGE_ONE_IDX: pcitr_cfg_word = IO_BASE | pcitr_pkg::CFG_IO_FLAG;
            default: pcitr_cfg_word = '0;
        endcase
    endfunction : pcitr_cfg_word

    // next-state logic: buffer, claim, data phases, local handshake
    always_comb
    begin
        logic phase_end;
        logic xfer_done;
        logic cfg_load;
        logic push;
        logic skip;
        logic mem_hit;
        logic io_hit;
        logic cfg_hit;
        logic [63:0] word;
        next_r = r;
        // a phase ends on irdyn with trdyn or stopn; data moves only with trdyn
        phase_end = (r.st == pcitr_pkg::T_DATA) && !bus.irdyn && (!r.trdyn || !r.stopn);
        xfer_done = phase_end && !r.trdyn;
        cfg_load = (r.st == pcitr_pkg::T_DATA) && r.cfg && !r.pushed;
        push = !r.xfer_n || cfg_load;
        // odd-dword start drops the low half of the first qword
        skip = r.cfg || (!r.pushed && r.addr[pcitr_pkg::QW_SEL_BIT]);
        word = r.cfg ? {pcitr_cfg_word(r.addr[7:2]), 32'h0000_0000} : local_data;
        mem_hit = 1'b0;
        io_hit = 1'b0;
        cfg_hit = 1'b0;
        next_r.fr_q = bus.framen;
        // drain side: one dword per completed phase, qword leaves after its high half
        if (xfer_done)
        begin
            if (r.hhalf)
            begin
                next_r.fifo[0] = r.fifo[1];
                next_r.occ = r.occ - 2'h1;
                next_r.hhalf = 1'b0;
            end
            else
            begin
                next_r.hhalf = 1'b1;
            end
        end
        // fill side: the whole qword is taken on each strobe
        if (push)
        begin
            next_r.fifo[next_r.occ[0]] = word;
            if (next_r.occ == 2'h0)
            begin
                next_r.hhalf = skip;
            end
            next_r.occ = next_r.occ + 2'h1;
            next_r.pushed = 1'b1;
        end
        // one-cycle report of a dword handed to the master
        next_r.tsv[pcitr_pkg::TSV_DONE] = xfer_done && !r.cfg;
        case (r.st)
            pcitr_pkg::T_IDLE:
            begin
                // falling framen marks the address phase
                if (!bus.framen && r.fr_q)
                begin
                    mem_hit = (bus.cben == pcitr_pkg::CMD_MEM_RD
                        || bus.cben == pcitr_pkg::CMD_MEM_RDM
                        || bus.cben == pcitr_pkg::CMD_MEM_RDL)
                        && ((bus.ad & MEM_MASK) == MEM_BASE);
                    // io byte-enable sanity is left to the local side
                    io_hit = (bus.cben == pcitr_pkg::CMD_IO_RD)
                        && ((bus.ad & IO_MASK) == IO_BASE);
                    cfg_hit = (bus.cben == pcitr_pkg::CMD_CFG_RD) && bus.idsel;
                end
                if (mem_hit || io_hit || cfg_hit)
                begin
                    next_r.st = pcitr_pkg::T_DECODE;
                    next_r.cmd = bus.cben;
                    next_r.addr = bus.ad;
                    next_r.cfg = cfg_hit;
                    next_r.io = io_hit;
                    next_r.wide = !bus.req64n;
                    next_r.hit = {io_hit, mem_hit};
                    next_r.issued = 1'b0;
                    next_r.pushed = 1'b0;
                    next_r.disc = 1'b0;
                    next_r.occ = 2'h0;
                    next_r.hhalf = 1'b0;
                end
            end
            pcitr_pkg::T_DECODE:
            begin
                // claim: devsel only, ack64n stays high on this 32-bit path
                next_r.st = pcitr_pkg::T_DATA;
                next_r.t_oe = 1'b1;
                next_r.devseln = 1'b0;
                if (!r.cfg)
                begin
                    next_r.tsv[pcitr_pkg::TSV_RANGE0] = r.hit[0];
                    next_r.tsv[pcitr_pkg::TSV_RANGE1] = r.hit[1];
                    next_r.tsv[pcitr_pkg::TSV_WIDE] = r.wide;
                end
            end
            pcitr_pkg::T_DATA:
            begin
                if (!bus.framen && !bus.irdyn && !r.cfg)
                begin
                    next_r.tsv[pcitr_pkg::TSV_BURST] = 1'b1;
                end
                // config reads always complete, whatever the local side asks
                if (!local_disc_n && !r.cfg)
                begin
                    next_r.disc = 1'b1;
                end
                if (phase_end && bus.framen)
                begin
                    next_r.st = pcitr_pkg::T_DONE;
                end
            end
            pcitr_pkg::T_DONE:
            begin
                // lines driven high for one cycle, status cleared at its end
                next_r.st = pcitr_pkg::T_IDLE;
                next_r.t_oe = 1'b0;
                next_r.tsv = '0;
            end
            default:
            begin
                next_r = T_RST;
            end
        endcase
        // local strobe: one cycle after ready, only while the buffer has room
        next_r.xfer_n = !(r.st == pcitr_pkg::T_DATA && next_r.st == pcitr_pkg::T_DATA
            && !r.cfg && !next_r.disc && !local_ready_n
            && next_r.occ <= 2'h1
            && !(r.io && r.issued));
        if (!next_r.xfer_n)
        begin
            next_r.issued = 1'b1;
        end
        // low-half ack off on an odd first qword; both acks idle on io
        next_r.ldat_n = !(!next_r.xfer_n && !r.io
            && !(!r.issued && r.addr[pcitr_pkg::QW_SEL_BIT]));
        next_r.hdat_n = !(!next_r.xfer_n && !r.io);
        next_r.lframe_n = !(next_r.st == pcitr_pkg::T_DATA && !r.cfg);
        // bus side follows the buffer head one cycle after the push
        next_r.ad_oe = (next_r.st == pcitr_pkg::T_DATA);
        next_r.ad = next_r.hhalf ? next_r.fifo[0][63:32] : next_r.fifo[0][31:0];
        // empty buffer holds trdyn off; config never waits on local ready
        next_r.trdyn = !(next_r.st == pcitr_pkg::T_DATA && next_r.occ != 2'h0);
        // single-dword kinds stop bursts, but only once data is on offer
        next_r.stopn = !(next_r.st == pcitr_pkg::T_DATA && ((r.cfg || r.io)
            ? (next_r.occ != 2'h0 || next_r.pushed) : next_r.disc));
        if (next_r.st != pcitr_pkg::T_DATA)
        begin
            next_r.devseln = 1'b1;
        end
        // parity covers the ad and cben seen in the previous cycle
        next_r.par = (^r.ad) ^ (^bus.cben);
        next_r.par_oe = r.ad_oe;
    end

    // state register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            r <= T_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign bus.t_ad = r.ad;
    assign bus.t_ad_oe = r.ad_oe;
    assign bus.t_oe = r.t_oe;
    assign bus.trdyn_o = r.trdyn;
    assign bus.devseln_o = r.devseln;
    assign bus.stopn_o = r.stopn;
    assign bus.ack64n_o = 1'b1;
    assign bus.par_o = r.par;
    assign bus.par_oe = r.par_oe;
    assign local_xfer_strobe_n = r.xfer_n;
    assign local_ldat_ack_n = r.ldat_n;
    assign local_hdat_ack_n = r.hdat_n;
    assign local_frame_n = r.lframe_n;
    assign local_command_out = r.cmd;
    assign local_addr_out = r.addr;
    assign target_status_vector = r.tsv;
endmodule : pcitr_target

// File: pcitr_asserts.sv
`timescale 1ns/100ps
module pcitr_asserts
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [31:0] ad,
    input wire logic [3:0] cben,
    input wire logic framen,
    input wire logic irdyn,
    input wire logic idsel,
    input wire logic trdyn,
    input wire logic devseln,
    input wire logic ack64n,
    input wire logic par,
    input wire logic par_oe,
    input wire logic t_ad_oe,
    input wire logic local_ready_n,
    input wire logic local_xfer_strobe_n,
    input wire logic local_frame_n,
    input wire logic [11:0] target_status_vector
);
    // single clock domain, so one clocking and one disable serve all
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // address phase of a config read, with the select line as given
    sequence cfg_go(logic sel);
        $fell(framen) && cben == pcitr_pkg::CMD_CFG_RD && idsel == sel;
    endsequence
    ready_gate_a: assert property (!local_xfer_strobe_n |-> !$past(local_ready_n))
        else $error("strobe without ready");
    no_wide_ack_a: assert property (!devseln |-> ack64n)
        else $error("wide ack on narrow read");
    narrow_flag_a: assert property (!local_frame_n |-> !target_status_vector[7])
        else $error("wide flag on narrow read");
    // parity trails the ad value by one cycle, even over ad and cben
    parity_lag_a: assert property ($past(t_ad_oe)
        |-> par_oe && par == ^{$past(ad), $past(cben)})
        else $error("parity wrong");
    mem_wait_a: assert property ($fell(framen) && cben == pcitr_pkg::CMD_MEM_RD
        |-> trdyn [*4])
        else $error("data before local transfer");
    cfg_select_a: assert property (cfg_go(1'b0) |=> devseln [*4])
        else $error("config claimed without select");
    cfg_early_a: assert property (cfg_go(1'b1) |-> ##3 !trdyn)
        else $error("config data not early");
    cfg_local_a: assert property (cfg_go(1'b1)
        |-> (local_xfer_strobe_n && local_frame_n) [*6])
        else $error("config touched local side");
    burst_flag_a: assert property (!local_frame_n && !framen && !irdyn
        |=> target_status_vector[9])
        else $error("burst bit not set");
    // every dword handed over on a mem or io read is reported next cycle
    done_pulse_a: assert property (!local_frame_n && !trdyn && !irdyn
        |=> target_status_vector[10])
        else $error("transfer not reported");
    cfg_seen_c: cover property (cfg_go(1'b1) ##3 !trdyn);
    burst_seen_c: cover property (target_status_vector[9]);
    stall_seen_c: cover property (!local_frame_n && local_ready_n);
endmodule : pcitr_asserts

// File: pci_target_read_path_bench.sv
`timescale 1ns/100ps
module pci_target_read_path_bench;
    localparam logic [31:0] KEY = 32'h5c3a_0000; // local data pattern
    localparam logic [31:0] ID_WORD = 32'h1234_00c3; // arbitrary identity word
    logic clk, arst_n, cmd_valid, cmd_ready, cmd_cfg, rd_valid, done, aborted;
    logic [3:0] cmd_code, cur_cmd;
    logic [31:0] cmd_addr, rd_data, cur_addr, qa;
    logic [7:0] cmd_count;
    logic local_ready_n, local_disc_n, strobe_n, ldat_n, hdat_n, lframe_n, s, first;
    logic [63:0] local_data;
    logic [3:0] lcmd;
    logic [11:0] tsv;
    logic [31:0] laddr; // latched address seen on the local side
    logic [1:0] acks;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    pcitr_if bus_if();
    pcitr_master u_pcitr_master (.clk(clk), .arst_n(arst_n), .bus(bus_if),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
        .cmd_count(cmd_count), .cmd_cfg(cmd_cfg), .rd_valid(rd_valid), .rd_data(rd_data),
        .done(done), .aborted(aborted));
    pcitr_target #(.CFG_ID(ID_WORD)) u_pcitr_target (.clk(clk), .arst_n(arst_n), .bus(bus_if),
        .local_ready_n(local_ready_n), .local_disc_n(local_disc_n), .local_data(local_data),
        .local_xfer_strobe_n(strobe_n), .local_ldat_ack_n(ldat_n), .local_hdat_ack_n(hdat_n),
        .local_frame_n(lframe_n), .local_command_out(lcmd), .local_addr_out(laddr),
        .target_status_vector(tsv));
    pcitr_asserts u_pcitr_asserts (.clk(clk), .arst_n(arst_n), .ad(bus_if.ad),
        .cben(bus_if.cben), .framen(bus_if.framen), .irdyn(bus_if.irdyn), .idsel(bus_if.idsel),
        .trdyn(bus_if.trdyn), .devseln(bus_if.devseln), .ack64n(bus_if.ack64n),
        .par(bus_if.par), .par_oe(bus_if.par_oe), .t_ad_oe(bus_if.t_ad_oe),
        .local_ready_n(local_ready_n), .local_xfer_strobe_n(strobe_n),
        .local_frame_n(lframe_n), .target_status_vector(tsv));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp
    // one read through the master; e is the word a config read must return
    task automatic rd(input logic [3:0] c, input logic [31:0] a, input int n, input logic g,
        input logic [31:0] e, input int want, input string name);
        int i;
        i = 0;
        cur_addr = a;
        cur_cmd = c;
        cmd_code = c;
        cmd_addr = a;
        cmd_count = 8'(n);
        cmd_cfg = g;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1)
        begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        forever
        begin
            @(posedge clk);
            #1;
            if (rd_valid === 1'b1)
            begin
                cmp(rd_data, g ? e : ((a + 32'(4 * i)) ^ KEY), name);
                i++;
            end
            if (done === 1'b1 || aborted === 1'b1)
                break;
        end
        cmp(32'(i), 32'(want), name);
        cmp({31'h0, aborted}, {31'h0, want == 0}, name);
        repeat (2) @(posedge clk);
        #1;
        $display("test %s ended", name);
    endtask : rd
    // local side: supplies the qword at qa, checks status on each strobe and acks on every strobe but io
    always @(posedge clk)
    begin
        s = strobe_n;
        acks = {ldat_n, hdat_n};
        #1;
        if (lframe_n === 1'b1)
        begin
            qa = {cur_addr[31:3], 3'h0};
            first = 1'b1;
        end
        else if (s === 1'b0)
        begin
            if (cur_cmd != pcitr_pkg::CMD_IO_RD)
                cmp({30'h0, acks}, {30'h0, first && cur_addr[2], 1'b0}, "acks");
            cmp({20'h0, tsv[1:0], lcmd}, {20'h0, cur_cmd == 4'h2, cur_cmd != 4'h2,
                cur_cmd}, "kind");
            cmp(laddr, cur_addr, "addr");
            qa = qa + 32'h8;
            first = 1'b0;
        end
        local_data = {(qa + 32'h4) ^ KEY, qa ^ KEY};
    end
    // watchdog: the whole sequence needs well under this many cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            $display("mismatch at %0t: timeout", $time);
            give_verdict();
        end
    end
    initial
    begin
        {arst_n, cmd_valid, cmd_cfg, local_ready_n, cmd_code, cmd_addr, cmd_count} = '0;
        {cur_cmd, cur_addr, qa, local_data, first} = '0;
        local_disc_n = 1'b1;
        repeat (12) @(posedge clk);
        #1;
        arst_n = 1'b1;
        rd(pcitr_pkg::CMD_MEM_RD, 32'h1000_0020, 1, 1'b0, 0, 1, "aligned");
        rd(pcitr_pkg::CMD_MEM_RD, 32'h1000_0024, 1, 1'b0, 0, 1, "odd");
        fork
            rd(pcitr_pkg::CMD_MEM_RDM, 32'h1000_0044, 6, 1'b0, 0, 6, "stall");
            begin
                @(negedge strobe_n);
                @(posedge clk);
                #1;
                local_ready_n = 1'b1;
                repeat (3) @(posedge clk);
                #1;
                local_ready_n = 1'b0;
            end
        join
        rd(pcitr_pkg::CMD_MEM_RDL, 32'h1000_0080, 4, 1'b0, 0, 4, "burst");
        // a non-prefetching local side stops the burst after its first qword
        fork
            rd(pcitr_pkg::CMD_MEM_RDL, 32'h1000_00c0, 4, 1'b0, 0, 2, "disconnect");
            begin
                @(negedge strobe_n);
                #1;
                local_disc_n = 1'b0;
            end
        join
        local_disc_n = 1'b1;
        rd(pcitr_pkg::CMD_IO_RD, 32'h0000_1008, 1, 1'b0, 0, 1, "io");
        local_ready_n = 1'b1;
        local_disc_n = 1'b0;
        rd(pcitr_pkg::CMD_CFG_RD, 32'h0, 1, 1'b1, ID_WORD, 1, "cfg id");
        rd(pcitr_pkg::CMD_CFG_RD, 32'h10, 1, 1'b1, 32'h1000_0000, 1, "cfg base");
        rd(pcitr_pkg::CMD_CFG_RD, 32'h0, 1, 1'b0, 0, 0, "cfg unselected");
        give_verdict();
    end
endmodule : pci_target_read_path_bench
